// ===== verilog/rfad_map.vh
`ifndef RFAD_MAP_VH
`define RFAD_MAP_VH

// Register byte offsets on the AXI4-Lite bus.
`define RFAD_REG_CTRL      8'h00
`define RFAD_REG_STATUS    8'h04
`define RFAD_REG_IRQ_STAT  8'h08
`define RFAD_REG_IRQ_MASK  8'h0c
`define RFAD_REG_STATE     8'h10

// Control bits.
`define RFAD_CTRL_WIP      0
`define RFAD_CTRL_PFAIL    1
`define RFAD_CTRL_LFAIL    2

// Interrupt status and mask bits.
`define RFAD_IRQ_DONE      0
`define RFAD_IRQ_NVM       1
`define RFAD_IRQ_ERR       2
`define RFAD_IRQ_DROP      3

// Tag states.
`define RFAD_ST_READY      2'h0
`define RFAD_ST_SELECTED   2'h1
`define RFAD_ST_QUIET      2'h2

// Command codes.
`define RFAD_CMD_RTR       8'h26
`define RFAD_CMD_WAFI      8'h27
`define RFAD_CMD_LAFI      8'h28
`define RFAD_CMD_WDSFID    8'h29
`define RFAD_CMD_LDSFID    8'h2a

// Error codes.
`define RFAD_E_OPTION      8'h03
`define RFAD_E_RELOCK      8'h11
`define RFAD_E_LOCKED      8'h12
`define RFAD_E_PROG        8'h13
`define RFAD_E_LOCK        8'h14

// Request flag positions and response flag values.
`define RFAD_FLAG_ADDR     5
`define RFAD_FLAG_OPT      6
`define RFAD_RSP_OK        8'h00
`define RFAD_RSP_ERR       8'h01

// CRC16 with reflected polynomial, preset and good residue.
`define RFAD_CRC_INIT      16'hffff
`define RFAD_CRC_POLY      16'h8408
`define RFAD_CRC_RESIDUE   16'hf0b8

// Reset values of the nonvolatile bytes.
`define RFAD_AFI_RESET     8'h00
`define RFAD_DSFID_RESET   8'h00

// Timing, times in ns, rounded up to whole cycles of the 50 MHz clock.
`define RFAD_CLK_MHZ       50
`define RFAD_NOMINAL_RESPONSE_DELAY_NS      320900
`define RFAD_WT_STEP_NS    302000
`define RFAD_WT_STEPS      18
`define RFAD_WT_NS         (`RFAD_NOMINAL_RESPONSE_DELAY_NS + `RFAD_WT_STEPS * `RFAD_WT_STEP_NS)
`define RFAD_NOMINAL_RESPONSE_DELAY_CYC     ((`RFAD_NOMINAL_RESPONSE_DELAY_NS * `RFAD_CLK_MHZ + 999) / 1000)
`define RFAD_WT_CYC        ((`RFAD_WT_NS * `RFAD_CLK_MHZ + 999) / 1000)

`endif

// ===== verilog/rfad_cmd_handler.v
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "rfad_map.vh"
// What this block does
// - Reset to Ready moves tag to Ready.
// - Addressed request answers only matching UID.
// - Unsupported option on Reset reports 03h.
// - Request: flags, command, UID, parameter, CRC.
// - Success response: flags and CRC only.
// - Error response: flags, error code, CRC.
// - Write AFI programs the AFI byte.
// - Write refused 12h locked, 13h failed.
// - Lock AFI locks AFI for good.
// - Lock refused 11h relock, 14h failed.
// - Write DSFID programs the DSFID byte.
// - Lock DSFID locks DSFID for good.
// - Busy mode: pin low SOF to response end.
// - Write mode: pin released for Reset.
// - Write mode: pin low during write cycle.
module rfad_cmd_handler #(
	parameter integer RESP_DELAY_CYC = `RFAD_NOMINAL_RESPONSE_DELAY_CYC,
	parameter integer WRITE_CYC      = `RFAD_WT_CYC,
	// Arbitrary UID value, replace per device.
	parameter [63:0]  TAG_UID        = 64'h0123456789abcdef
)(
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite slave
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// RF link
	input  wire        rf_link_clk,
	input  wire        rf_rx_frame,
	input  wire        rf_rx_data,
	output reg         rf_tx_frame,
	output reg         rf_tx_data,
	// Activity pin and interrupt
	output wire        rf_activity_pin_o,
	output reg         rf_activity_pin_oe,
	output wire        irq
);

localparam [1:0] ST_IDLE = 2'd0;
localparam [1:0] ST_RX   = 2'd1;
localparam [1:0] ST_WAIT = 2'd2;
localparam [1:0] ST_TX   = 2'd3;
localparam [31:0] RD32   = RESP_DELAY_CYC;
localparam [31:0] WC32   = WRITE_CYC;

function [15:0] crc_byte;
	input [15:0] c;
	input [7:0]  d;
	integer      k;
	reg   [15:0] r;
	begin
		r = c ^ {8'h00, d};
		for (k = 0; k < 8; k = k + 1)
			r = r[0] ? ((r >> 1) ^ `RFAD_CRC_POLY) : (r >> 1);
		crc_byte = r;
	end
endfunction

reg  [1:0]  st;
reg  [2:0]  s_clk;
reg  [2:0]  s_frm;
reg  [1:0]  s_dat;
reg  [2:0]  bit_cnt;
reg  [3:0]  byte_cnt;
reg  [7:0]  sh;
reg  [15:0] crc;
reg  [19:0] wait_cnt;
reg  [7:0]  p_cmd;
reg  [7:0]  p_par;
reg  [7:0]  p_err;
reg         p_long;
reg  [31:0] tx_sh;
reg  [5:0]  tx_left;
reg  [7:0]  rq_err;
reg  [2:0]  ctrl;
reg  [3:0]  irq_stat;
reg  [3:0]  irq_mask;
reg  [1:0]  tag_state;
reg  [7:0]  afi;
reg  [7:0]  dsfid;
reg         afi_lock;
reg         ds_lock;
reg         aw_hold;
reg  [7:0]  aw_addr;
reg         w_hold;
reg  [31:0] w_data;
reg  [3:0]  w_strb;
reg  [31:0] rd_val;
reg         rd_ok;

// Only the second and third stages are looked at; the first may be metastable.
wire lrise = s_clk[1] & ~s_clk[2];
wire lfall = ~s_clk[1] & s_clk[2];
wire sof   = s_frm[1] & ~s_frm[2];
wire eof   = ~s_frm[1] & s_frm[2];

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		s_clk <= 3'h0;
		s_frm <= 3'h0;
		s_dat <= 2'h0;
	end
	else
	begin
		s_clk <= {s_clk[1:0], rf_link_clk};
		s_frm <= {s_frm[1:0], rf_rx_frame};
		s_dat <= {s_dat[0], rf_rx_data};
	end
end

// Bits arrive least significant first, sampled on the link clock's rising edge.
wire       bit_in    = (st == ST_RX) && lrise && s_frm[1];
wire       byte_done = bit_in && (bit_cnt == 3'd7);
wire [7:0] byte_val  = {s_dat[1], sh[7:1]};
wire [95:0] rxf;

genvar gi;
generate
	for (gi = 0; gi < 12; gi = gi + 1)
	begin : g_rxb
		localparam integer IDX = gi;
		reg [7:0] b;
		always @(posedge aclk)
		begin
			if (!aresetn)
				b <= 8'h00;
			else if (byte_done && {28'h0, byte_cnt} == IDX)
				b <= byte_val;
		end
		assign rxf[gi*8 +: 8] = b;
	end
endgenerate

wire [7:0]  rq_flags = rxf[7:0];
wire [7:0]  rq_cmd   = rxf[15:8];
wire [63:0] rq_uid   = rxf[79:16];
wire        rq_addr  = rq_flags[`RFAD_FLAG_ADDR];
wire        rq_opt   = rq_flags[`RFAD_FLAG_OPT];
wire [7:0]  rq_par   = rq_addr ? rxf[87:80] : rxf[23:16];
wire        has_par  = (rq_cmd == `RFAD_CMD_WAFI) || (rq_cmd == `RFAD_CMD_WDSFID);
wire        known    = (rq_cmd >= `RFAD_CMD_RTR) && (rq_cmd <= `RFAD_CMD_LDSFID);
wire [3:0]  exp_len  = 4'd4 + (rq_addr ? 4'd8 : 4'd0) + {3'd0, has_par};
wire        uid_ok   = !rq_addr || (rq_uid == TAG_UID);
wire        frame_ok = (bit_cnt == 3'd0) && (byte_cnt == exp_len) &&
                       (crc == `RFAD_CRC_RESIDUE) && known && uid_ok;

always @*
begin
	rq_err = 8'h00;
	case (rq_cmd)
		`RFAD_CMD_RTR:
			rq_err = rq_opt ? `RFAD_E_OPTION : 8'h00;
		`RFAD_CMD_WAFI:
			rq_err = afi_lock ? `RFAD_E_LOCKED :
			         ctrl[`RFAD_CTRL_PFAIL] ? `RFAD_E_PROG : 8'h00;
		`RFAD_CMD_LAFI:
			rq_err = afi_lock ? `RFAD_E_RELOCK :
			         ctrl[`RFAD_CTRL_LFAIL] ? `RFAD_E_LOCK : 8'h00;
		`RFAD_CMD_WDSFID:
			rq_err = ds_lock ? `RFAD_E_LOCKED :
			         ctrl[`RFAD_CTRL_PFAIL] ? `RFAD_E_PROG : 8'h00;
		`RFAD_CMD_LDSFID:
			rq_err = ds_lock ? `RFAD_E_RELOCK :
			         ctrl[`RFAD_CTRL_LFAIL] ? `RFAD_E_LOCK : 8'h00;
		default:
			rq_err = 8'h00;
	endcase
end

// A locked byte is refused at once; every other write or lock runs the full cycle.
wire rq_long = (rq_cmd != `RFAD_CMD_RTR) && (rq_err != `RFAD_E_LOCKED) &&
               (rq_err != `RFAD_E_RELOCK);

wire        commit = (st == ST_WAIT) && (wait_cnt == 20'd1);
wire        p_ok   = (p_err == 8'h00);
wire [15:0] c_fl   = crc_byte(`RFAD_CRC_INIT, p_ok ? `RFAD_RSP_OK : `RFAD_RSP_ERR);
wire [15:0] c_all  = ~(p_ok ? c_fl : crc_byte(c_fl, p_err));

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		st          <= ST_IDLE;
		bit_cnt     <= 3'd0;
		byte_cnt    <= 4'd0;
		sh          <= 8'h00;
		crc         <= `RFAD_CRC_INIT;
		wait_cnt    <= 20'd0;
		p_cmd       <= 8'h00;
		p_par       <= 8'h00;
		p_err       <= 8'h00;
		p_long      <= 1'b0;
		tx_sh       <= 32'h0;
		tx_left     <= 6'd0;
		rf_tx_frame <= 1'b0;
		rf_tx_data  <= 1'b0;
	end
	else
	begin
		case (st)
			ST_IDLE:
			begin
				if (sof)
				begin
					st       <= ST_RX;
					bit_cnt  <= 3'd0;
					byte_cnt <= 4'd0;
					crc      <= `RFAD_CRC_INIT;
				end
			end
			ST_RX:
			begin
				if (bit_in)
				begin
					sh      <= byte_val;
					bit_cnt <= bit_cnt + 3'd1;
					if (byte_done)
					begin
						crc <= crc_byte(crc, byte_val);
						if (byte_cnt != 4'hf)
							byte_cnt <= byte_cnt + 4'd1;
					end
				end
				if (eof)
				begin
					if (frame_ok)
					begin
						st       <= ST_WAIT;
						p_cmd    <= rq_cmd;
						p_par    <= rq_par;
						p_err    <= rq_err;
						p_long   <= rq_long;
						wait_cnt <= rq_long ? WC32[19:0] : RD32[19:0];
					end
					else
						st <= ST_IDLE;
				end
			end
			ST_WAIT:
			begin
				wait_cnt <= wait_cnt - 20'd1;
				if (commit)
				begin
					st <= ST_TX;
					if (p_ok)
					begin
						tx_sh   <= {8'h00, c_all, `RFAD_RSP_OK};
						tx_left <= 6'd24;
					end
					else
					begin
						tx_sh   <= {c_all, p_err, `RFAD_RSP_ERR};
						tx_left <= 6'd32;
					end
				end
			end
			ST_TX:
			begin
				// Response bits change on the falling link edge for the reader to sample.
				if (lfall)
				begin
					if (tx_left == 6'd0)
					begin
						rf_tx_frame <= 1'b0;
						rf_tx_data  <= 1'b0;
						st          <= ST_IDLE;
					end
					else
					begin
						rf_tx_frame <= 1'b1;
						rf_tx_data  <= tx_sh[0];
						tx_sh       <= {1'b0, tx_sh[31:1]};
						tx_left     <= tx_left - 6'd1;
					end
				end
			end
			default:
				st <= ST_IDLE;
		endcase
	end
end

// Nonvolatile bytes change only at the end of a successful write cycle.
always @(posedge aclk)
begin
	if (!aresetn)
	begin
		afi      <= `RFAD_AFI_RESET;
		dsfid    <= `RFAD_DSFID_RESET;
		afi_lock <= 1'b0;
		ds_lock  <= 1'b0;
	end
	else if (commit && p_ok)
	begin
		case (p_cmd)
			`RFAD_CMD_WAFI:
				afi <= p_par;
			`RFAD_CMD_LAFI:
				afi_lock <= 1'b1;
			`RFAD_CMD_WDSFID:
				dsfid <= p_par;
			`RFAD_CMD_LDSFID:
				ds_lock <= 1'b1;
			default:
				afi <= afi;
		endcase
	end
end

// Pin is open drain: it is only ever pulled low.
assign rf_activity_pin_o = 1'b0;

always @(posedge aclk)
begin
	if (!aresetn)
		rf_activity_pin_oe <= 1'b0;
	else if (ctrl[`RFAD_CTRL_WIP])
		rf_activity_pin_oe <= (st == ST_WAIT) && p_long;
	else
		rf_activity_pin_oe <= (st != ST_IDLE);
end

// AXI4-Lite write path: address and data are taken in either order.
assign s_axi_awready = !aw_hold;
assign s_axi_wready  = !w_hold;
assign s_axi_arready = !s_axi_rvalid;

wire do_wr  = aw_hold && w_hold && !s_axi_bvalid;
wire wr_b0  = do_wr && w_strb[0];
wire wr_map = (aw_addr == `RFAD_REG_CTRL) || (aw_addr == `RFAD_REG_IRQ_STAT) ||
              (aw_addr == `RFAD_REG_IRQ_MASK) || (aw_addr == `RFAD_REG_STATE);

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		aw_hold      <= 1'b0;
		aw_addr      <= 8'h00;
		w_hold       <= 1'b0;
		w_data       <= 32'h0;
		w_strb       <= 4'h0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp  <= 2'h0;
		ctrl         <= 3'h0;
		irq_mask     <= 4'h0;
	end
	else
	begin
		if (s_axi_awvalid && !aw_hold)
		begin
			aw_hold <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_hold)
		begin
			w_hold <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		if (do_wr)
		begin
			aw_hold      <= 1'b0;
			w_hold       <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_map ? 2'h0 : 2'h2;
		end
		else if (s_axi_bvalid && s_axi_bready)
			s_axi_bvalid <= 1'b0;
		if (wr_b0 && aw_addr == `RFAD_REG_CTRL)
			ctrl <= w_data[2:0];
		if (wr_b0 && aw_addr == `RFAD_REG_IRQ_MASK)
			irq_mask <= w_data[3:0];
	end
end

// Software may force a state; a completed Reset to Ready overrides it.
always @(posedge aclk)
begin
	if (!aresetn)
		tag_state <= `RFAD_ST_READY;
	else if (commit && p_ok && p_cmd == `RFAD_CMD_RTR)
		tag_state <= `RFAD_ST_READY;
	else if (wr_b0 && aw_addr == `RFAD_REG_STATE)
		tag_state <= w_data[1:0];
end

wire [3:0] ev;
assign ev[`RFAD_IRQ_DONE] = (st == ST_TX) && lfall && (tx_left == 6'd0);
assign ev[`RFAD_IRQ_NVM]  = commit && p_ok && (p_cmd != `RFAD_CMD_RTR);
assign ev[`RFAD_IRQ_ERR]  = commit && !p_ok;
assign ev[`RFAD_IRQ_DROP] = (st == ST_RX) && eof && !frame_ok;

// An event in the same cycle as its write-one-to-clear survives.
always @(posedge aclk)
begin
	if (!aresetn)
		irq_stat <= 4'h0;
	else if (wr_b0 && aw_addr == `RFAD_REG_IRQ_STAT)
		irq_stat <= (irq_stat & ~w_data[3:0]) | ev;
	else
		irq_stat <= irq_stat | ev;
end

assign irq = |(irq_stat & irq_mask);

always @*
begin
	rd_ok  = 1'b1;
	rd_val = 32'h0;
	case (s_axi_araddr)
		`RFAD_REG_CTRL:
			rd_val = {29'h0, ctrl};
		`RFAD_REG_STATUS:
			rd_val = {7'h0, (st != ST_IDLE), dsfid, afi, 4'h0, ds_lock, afi_lock, tag_state};
		`RFAD_REG_IRQ_STAT:
			rd_val = {28'h0, irq_stat};
		`RFAD_REG_IRQ_MASK:
			rd_val = {28'h0, irq_mask};
		`RFAD_REG_STATE:
			rd_val = {30'h0, tag_state};
		default:
			rd_ok = 1'b0;
	endcase
end

always @(posedge aclk)
begin
	if (!aresetn)
	begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata  <= 32'h0;
		s_axi_rresp  <= 2'h0;
	end
	else if (s_axi_arvalid && !s_axi_rvalid)
	begin
		s_axi_rvalid <= 1'b1;
		s_axi_rdata  <= rd_val;
		s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
	end
	else if (s_axi_rvalid && s_axi_rready)
		s_axi_rvalid <= 1'b0;
end

endmodule
`default_nettype wire

// ===== verif/rfad_cmd_handler_sva.sv
`timescale 1ns/10ps
`default_nettype none
module rfad_cmd_handler_sva (
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// AXI4-Lite
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// RF side
	input wire logic        rf_link_clk,
	input wire logic        rf_tx_frame,
	input wire logic        rf_activity_pin_o,
	input wire logic        rf_activity_pin_oe
);
	logic       link_q;
	logic [5:0] bit_cnt;
	// Link rises seen while a response is out give its length in bits.
	always @(posedge aclk)
	begin
		link_q <= rf_link_clk;
		if (!aresetn || !rf_tx_frame)
			bit_cnt <= 6'h00;
		else if (!link_q && rf_link_clk)
			bit_cnt <= bit_cnt + 6'h01;
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
	a_arready_low: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while one is pending");
	a_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_pin_level: assert property (rf_activity_pin_o == 1'b0)
		else $error("activity pin driven high");
	a_pin_release: assert property ($fell(rf_tx_frame) |-> ##[0:2] !rf_activity_pin_oe)
		else $error("activity pin held after response");
	a_pin_steady: assert property (rf_tx_frame && $past(rf_tx_frame) |->
		$stable(rf_activity_pin_oe)) else $error("activity pin moved during response");
	a_rsp_length: assert property ($fell(rf_tx_frame) |->
		bit_cnt == 6'h18 || bit_cnt == 6'h20) else $error("response length wrong");
	a_reset_quiet: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=>
		!s_axi_bvalid && !s_axi_rvalid && !rf_tx_frame && !rf_activity_pin_oe)
		else $error("outputs active in reset");
endmodule
bind rfad_cmd_handler rfad_cmd_handler_sva u_sva (.aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.rf_link_clk, .rf_tx_frame, .rf_activity_pin_o, .rf_activity_pin_oe);
`default_nettype wire

// ===== verif/rfad_reader.sv
`timescale 1ns/10ps
`default_nettype none
`include "rfad_map.vh"
module rfad_reader (
	// Link to the tag
	output var logic rf_link_clk,
	output var logic rf_rx_frame,
	output var logic rf_rx_data,
	input  wire logic rf_tx_frame,
	input  wire logic rf_tx_data
);
	logic [7:0]  req_buf [0:15];
	logic [31:0] rsp_bits;
	int          nb;
	initial
	begin
		rf_link_clk = 1'b0;
		rf_rx_frame = 1'b0;
		rf_rx_data = 1'b0;
	end
	function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] d);
		int i;
		c = c ^ {8'h00, d};
		for (i = 0; i < 8; i++)
			c = c[0] ? ((c >> 1) ^ `RFAD_CRC_POLY) : (c >> 1);
		return c;
	endfunction
	// The link clock runs only for one exchange; a bad CRC is forced on request.
	task automatic exchange(input int n, input logic bad);
		int i;
		int b;
		int k;
		logic [15:0] c;
		c = `RFAD_CRC_INIT;
		for (i = 0; i < n; i++)
			c = crc_add(c, req_buf[i]);
		c = ~c ^ {15'h0000, bad};
		req_buf[n] = c[7:0];
		req_buf[n + 1] = c[15:8];
		nb = 0;
		rsp_bits = 32'h00000000;
		#7 rf_rx_frame = 1'b1;
		#160;
		for (i = 0; i < n + 2; i++)
			for (b = 0; b < 8; b++)
			begin
				rf_rx_data = req_buf[i][b];
				#80 rf_link_clk = 1'b1;
				#80 rf_link_clk = 1'b0;
			end
		rf_rx_frame = 1'b0;
		rf_rx_data = 1'b0;
		// No modulation while the tag writes; the clock only paces the reply.
		for (k = 0; k < 200; k++)
		begin
			#80 rf_link_clk = 1'b1;
			if (rf_tx_frame === 1'b1)
			begin
				if (nb < 32)
					rsp_bits[nb] = rf_tx_data;
				nb++;
			end
			#80 rf_link_clk = 1'b0;
			if (nb > 0 && rf_tx_frame !== 1'b1)
				break;
		end
	endtask
endmodule
`default_nettype wire

// ===== verif/rfad_cmd_handler_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "rfad_map.vh"
module rfad_cmd_handler_tb;
	localparam int WR_CYC = 60;
	// Arbitrary tag identity.
	localparam logic [63:0] UID = 64'h8877665544332211;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
	logic        awready, wready, arready, link, rxf, rxd, txf, txd, pin, oe, irq;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0]  bresp, rresp, rr, br;
	int          fails, compares, cycles, oe_cnt;
	rfad_cmd_handler #(.RESP_DELAY_CYC(20), .WRITE_CYC(WR_CYC), .TAG_UID(UID)) uut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.rf_link_clk(link), .rf_rx_frame(rxf), .rf_rx_data(rxd), .rf_tx_frame(txf),
		.rf_tx_data(txd), .rf_activity_pin_o(pin), .rf_activity_pin_oe(oe), .irq(irq));
	rfad_reader rdr (.rf_link_clk(link), .rf_rx_frame(rxf), .rf_rx_data(rxd),
		.rf_tx_frame(txf), .rf_tx_data(txd));
	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	always @(posedge aclk)
	begin
		cycles++;
		if (oe === 1'b1)
			oe_cnt++;
		if (cycles == 60000)
		begin
			fails++;
			stop_test();
		end
	end
	task stop_test;
		if (fails == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("FAIL %0t saw %h expected %h", $time, got, exp);
		end
	endtask
	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_t, w_t, b_t;
		b_t = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_t)
		begin
			// Handshakes are judged mid-cycle, where they are settled for the coming edge.
			@(negedge aclk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = (bvalid === 1'b1);
			br = bresp;
			@(posedge aclk);
			if (aw_t)
				awvalid <= 1'b0;
			if (w_t)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask
	task axi_rd(input logic [7:0] a);
		logic ar_t, r_t;
		r_t = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_t)
		begin
			@(negedge aclk);
			ar_t = arvalid && arready;
			r_t = (rvalid === 1'b1);
			rd = rdata;
			rr = rresp;
			@(posedge aclk);
			if (ar_t)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask
	task st(input logic [31:0] m, input logic [31:0] e);
		axi_rd(`RFAD_REG_STATUS);
		chk(rd & m, e);
	endtask
	task cmd(input logic [7:0] fl, cd, pr, input logic bad, wrg, input int eb, input logic [7:0] ec);
		int i;
		int n;
		logic [15:0] c;
		rdr.req_buf[0] = fl;
		rdr.req_buf[1] = cd;
		for (i = 0; i < 8; i++)
			rdr.req_buf[2 + i] = UID[8*i +: 8] ^ {7'h00, wrg};
		n = fl[`RFAD_FLAG_ADDR] ? 10 : 2;
		rdr.req_buf[n] = pr;
		if (cd == `RFAD_CMD_WAFI || cd == `RFAD_CMD_WDSFID)
			n++;
		oe_cnt = 0;
		rdr.exchange(n, bad);
		chk(rdr.nb, eb);
		if (eb > 0)
		begin
			chk(rdr.rsp_bits[7:0], eb == 32 ? `RFAD_RSP_ERR : `RFAD_RSP_OK);
			if (eb == 32)
				chk(rdr.rsp_bits[15:8], ec);
			c = `RFAD_CRC_INIT;
			for (i = 0; i < eb / 8; i++)
				c = rdr.crc_add(c, rdr.rsp_bits[8*i +: 8]);
			chk(c, `RFAD_CRC_RESIDUE);
		end
	endtask
	task t_reset;
		axi_wr(`RFAD_REG_STATUS, 32'hffffffff);
		chk(br, 2'h2);
		axi_wr(`RFAD_REG_STATE, 32'h0);
		chk(br, 2'h0);
		st(32'hffffffff, 32'h00000000);
		axi_rd(8'h40);
		chk(rr, 2'h2);
	endtask
	task t_write_afi;
		axi_wr(`RFAD_REG_IRQ_MASK, 32'hf);
		cmd(8'h02, `RFAD_CMD_WAFI, 8'h5a, 0, 0, 24, 0);
		chk(oe_cnt >= WR_CYC + 192, 1);
		st(32'hff00, 32'h5a00);
		chk(irq, 1'b1);
		axi_wr(`RFAD_REG_IRQ_MASK, 32'h0);
		chk(irq, 1'b0);
		axi_wr(`RFAD_REG_IRQ_MASK, 32'hf);
		chk(irq, 1'b1);
		axi_wr(`RFAD_REG_IRQ_STAT, 32'hf);
		chk(irq, 1'b0);
	endtask
	task t_wip;
		axi_wr(`RFAD_REG_CTRL, 32'h1);
		cmd(8'h02, `RFAD_CMD_RTR, 0, 0, 0, 24, 0);
		chk(oe_cnt, 0);
		cmd(8'h02, `RFAD_CMD_WDSFID, 8'h3c, 0, 0, 24, 0);
		chk(oe_cnt >= WR_CYC && oe_cnt <= WR_CYC + 10, 1);
		axi_wr(`RFAD_REG_CTRL, 32'h0);
	endtask
	task t_dsfid_lock_afi;
		cmd(8'h62, `RFAD_CMD_WDSFID, 8'ha5, 0, 0, 24, 0);
		st(32'hff0000, 32'ha50000);
		cmd(8'h02, `RFAD_CMD_LAFI, 0, 0, 0, 24, 0);
		cmd(8'h02, `RFAD_CMD_LAFI, 0, 0, 0, 32, `RFAD_E_RELOCK);
		cmd(8'h22, `RFAD_CMD_WAFI, 8'h33, 0, 0, 32, `RFAD_E_LOCKED);
		st(32'hff04, 32'h5a04);
	endtask
	task t_fail;
		axi_wr(`RFAD_REG_CTRL, 32'h2);
		cmd(8'h02, `RFAD_CMD_WDSFID, 8'h77, 0, 0, 32, `RFAD_E_PROG);
		st(32'hff0000, 32'ha50000);
		axi_wr(`RFAD_REG_CTRL, 32'h4);
		cmd(8'h02, `RFAD_CMD_LDSFID, 0, 0, 0, 32, `RFAD_E_LOCK);
		axi_wr(`RFAD_REG_CTRL, 32'h0);
		cmd(8'h42, `RFAD_CMD_LDSFID, 0, 0, 0, 24, 0);
		cmd(8'h02, `RFAD_CMD_WDSFID, 8'h77, 0, 0, 32, `RFAD_E_LOCKED);
		st(32'hff000c, 32'ha5000c);
	endtask
	task t_rtr;
		axi_wr(`RFAD_REG_STATE, 32'h1);
		cmd(8'h02, `RFAD_CMD_RTR, 0, 0, 0, 24, 0);
		st(32'h3, 32'h0);
		axi_wr(`RFAD_REG_STATE, 32'h1);
		cmd(8'h42, `RFAD_CMD_RTR, 0, 0, 0, 32, `RFAD_E_OPTION);
		cmd(8'h22, `RFAD_CMD_RTR, 0, 0, 1, 0, 0);
		cmd(8'h62, `RFAD_CMD_RTR, 0, 0, 0, 32, `RFAD_E_OPTION);
		cmd(8'h02, `RFAD_CMD_RTR, 0, 1, 0, 0, 0);
		st(32'h3, 32'h1);
		axi_rd(`RFAD_REG_IRQ_STAT);
		chk(rd, 32'hf);
	endtask
	initial
	begin
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_write_afi();
		t_wip();
		t_dsfid_lock_afi();
		t_fail();
		t_rtr();
		stop_test();
	end
endmodule
`default_nettype wire
